// ==== umcl_regs.svh ====
// Overview of operation
// - control bit 4 selects local loopback; default zero means normal.
// - loopback isolates serial out, serial in and all modem inputs.
// - loopback closes modem data and control paths internally.
// - receiver and transmitter interrupts keep working in loopback.
// - in loopback, modem status events come from control bits 3:0.
// - interrupt enable register gates every source, loopback or not.
// - control bit 3 drives user output two inverted in normal mode.
// - in loopback, control bit 3 sets carrier-detect status bit 7.
// - control bit 2 drives no pin; in loopback it stands for ring.
// - control bit 1 drives request-to-send low when set in normal mode; default high.
// - control bit 0 drives terminal-ready low when set in normal mode; default high.
`ifndef UMCL_REGS_SVH
`define UMCL_REGS_SVH

`define UMCL_ADDR_CTL 8'h00
`define UMCL_ADDR_MST 8'h04
`define UMCL_ADDR_MASK 8'h08
`define UMCL_ADDR_IST 8'h0c

`define UMCL_CTL_RST 5'h00
`define UMCL_IRQ_RST 6'h00
`define UMCL_CTL_DTR 0
`define UMCL_CTL_RTS 1
`define UMCL_CTL_RING 2
`define UMCL_CTL_USR2 3
`define UMCL_CTL_LOOP 4
`define UMCL_RSV_HI 7
`define UMCL_RSV_LO 5
`define UMCL_SYNC_SER 4

`define UMCL_EV_CTS 0
`define UMCL_EV_DSR 1
`define UMCL_EV_RI 2
`define UMCL_EV_CD 3
`define UMCL_EV_RX 4
`define UMCL_EV_TX 5

`define UMCL_HTRANS_NONSEQ 2'h2
`define UMCL_HTRANS_SEQ 2'h3
`define UMCL_SYNC_RST 5'h1f

`endif

// ==== umcl_pkg.sv ====
package umcl_pkg;
    // modem line states, active high
    typedef struct packed {
        logic cd;
        logic ri;
        logic dsr;
        logic cts;
    } umcl_modem_type;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic valid;
    } umcl_bus_req_type;
endpackage

// ==== umcl_top.sv ====
`timescale 1ns/1ps
`include "umcl_regs.svh"

module umcl_top (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_serial_in,
    input wire logic i_clear_to_send_in_n,
    input wire logic i_data_set_ready_in_n,
    input wire logic i_carrier_detect_in_n,
    input wire logic i_call_alert_in_n,
    input wire logic i_tx_bit,
    input wire logic i_rx_event,
    input wire logic i_tx_event,
    output logic o_serial_out,
    output logic o_rx_bit,
    output logic o_request_send_out_n,
    output logic o_terminal_ready_out_n,
    output logic o_user_output_two_n,
    output umcl_pkg::umcl_modem_type o_modem_status,
    output logic o_irq
);
    import umcl_pkg::*;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    logic [4:0] ctl_q;
    logic [5:0] mask_q;
    logic [5:0] ist_q;
    logic [5:0] ist_d;
    logic [5:0] ev_set;
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    umcl_modem_type pin_st;
    umcl_modem_type mst_d;
    umcl_modem_type mst_q;
    umcl_bus_req_type req_q;
    logic addr_ok;
    logic rd_pend_q;
    logic [31:0] rdata;
    logic loop;
    logic rx_pin;

    assign loop = ctl_q[`UMCL_CTL_LOOP];

    // bus address phase, only while the bus is ready
    assign addr_ok = i_hsel && i_hready &&
        (i_htrans == `UMCL_HTRANS_NONSEQ || i_htrans == `UMCL_HTRANS_SEQ);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            req_q <= '0;
        end else if (i_hready) begin
            req_q.addr <= i_haddr[7:0];
            req_q.write <= i_hwrite;
            req_q.valid <= addr_ok;
        end
    end

    // reads take one wait state so a preceding write is visible
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_pend_q <= 1'b0;
            o_hreadyout <= 1'b1;
        end else if (addr_ok && !i_hwrite) begin
            rd_pend_q <= 1'b1;
            o_hreadyout <= 1'b0;
        end else begin
            rd_pend_q <= 1'b0;
            o_hreadyout <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_hresp <= 1'b0;
        end else begin
            o_hresp <= 1'b0;
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        if (req_q.addr == `UMCL_ADDR_CTL) begin
            rdata[4:0] = ctl_q;
        end else if (req_q.addr == `UMCL_ADDR_MST) begin
            rdata[7:4] = mst_q;
            rdata[3:0] = ist_q[3:0];
        end else if (req_q.addr == `UMCL_ADDR_MASK) begin
            rdata[5:0] = mask_q;
        end else if (req_q.addr == `UMCL_ADDR_IST) begin
            rdata[5:0] = ist_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_hrdata <= 32'h0000_0000;
        end else if (rd_pend_q) begin
            o_hrdata <= rdata;
        end
    end

    // reserved bits 7:5 are not stored and read as zero
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctl_q <= `UMCL_CTL_RST;
        end else if (req_q.valid && req_q.write &&
                     req_q.addr == `UMCL_ADDR_CTL) begin
            ctl_q <= i_hwdata[4:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mask_q <= `UMCL_IRQ_RST;
        end else if (req_q.valid && req_q.write &&
                     req_q.addr == `UMCL_ADDR_MASK) begin
            mask_q <= i_hwdata[5:0];
        end
    end

    // pin inputs: two flops, pins idle high
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_q <= `UMCL_SYNC_RST;
            sync2_q <= `UMCL_SYNC_RST;
        end else begin
            sync1_q <= {i_serial_in, i_carrier_detect_in_n,
                i_call_alert_in_n, i_data_set_ready_in_n,
                i_clear_to_send_in_n};
            sync2_q <= sync1_q;
        end
    end

    assign rx_pin = sync2_q[`UMCL_SYNC_SER];
    assign pin_st = umcl_modem_type'(~sync2_q[3:0]);

    // loopback swaps pins for control bits
    always_comb begin
        if (loop) begin
            mst_d.cd = ctl_q[`UMCL_CTL_USR2];
            mst_d.ri = ctl_q[`UMCL_CTL_RING];
            mst_d.dsr = ctl_q[`UMCL_CTL_DTR];
            mst_d.cts = ctl_q[`UMCL_CTL_RTS];
        end else begin
            mst_d = pin_st;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mst_q <= '0;
        end else begin
            mst_q <= mst_d;
        end
    end

    assign o_modem_status = mst_q;

    // ring event only on the trailing edge, as on classic parts
    always_comb begin
        ev_set = '0;
        ev_set[`UMCL_EV_CTS] = mst_d.cts ^ mst_q.cts;
        ev_set[`UMCL_EV_DSR] = mst_d.dsr ^ mst_q.dsr;
        ev_set[`UMCL_EV_RI] = mst_q.ri & ~mst_d.ri;
        ev_set[`UMCL_EV_CD] = mst_d.cd ^ mst_q.cd;
        ev_set[`UMCL_EV_RX] = i_rx_event;
        ev_set[`UMCL_EV_TX] = i_tx_event;
    end

    // write one to clear; a same-cycle event wins
    always_comb begin
        ist_d = ist_q;
        if (req_q.valid && req_q.write &&
            req_q.addr == `UMCL_ADDR_IST) begin
            ist_d = ist_q & ~i_hwdata[5:0];
        end
        ist_d = ist_d | ev_set;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ist_q <= `UMCL_IRQ_RST;
        end else begin
            ist_q <= ist_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(ist_q & mask_q);
        end
    end

    // serial path; loopback parks the line at mark
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_serial_out <= 1'b1;
            o_rx_bit <= 1'b1;
        end else if (loop) begin
            o_serial_out <= 1'b1;
            o_rx_bit <= i_tx_bit;
        end else begin
            o_serial_out <= i_tx_bit;
            o_rx_bit <= rx_pin;
        end
    end

    // modem outputs are active low and idle in loopback
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_request_send_out_n <= 1'b1;
            o_terminal_ready_out_n <= 1'b1;
            o_user_output_two_n <= 1'b1;
        end else if (loop) begin
            o_request_send_out_n <= 1'b1;
            o_terminal_ready_out_n <= 1'b1;
            o_user_output_two_n <= 1'b1;
        end else begin
            o_request_send_out_n <= ~ctl_q[`UMCL_CTL_RTS];
            o_terminal_ready_out_n <= ~ctl_q[`UMCL_CTL_DTR];
            o_user_output_two_n <= ~ctl_q[`UMCL_CTL_USR2];
        end
    end

    AST_LOOP_TX_MARK: assert property (
        loop |=> o_serial_out)
        else $error("serial out not at mark in loopback");

    AST_LOOP_RX_FEED: assert property (
        loop |=> o_rx_bit == $past(i_tx_bit))
        else $error("rx not fed from tx in loopback");

    AST_RX_FROM_PIN: assert property (
        !loop |=> o_rx_bit == $past(rx_pin))
        else $error("rx not from pin in normal mode");

    AST_RTS_PIN: assert property (
        !loop |=> o_request_send_out_n == !$past(ctl_q[`UMCL_CTL_RTS]))
        else $error("request to send pin wrong");

    AST_DTR_PIN: assert property (
        !loop |=> o_terminal_ready_out_n == !$past(ctl_q[`UMCL_CTL_DTR]))
        else $error("terminal ready pin wrong");

    AST_OP2_PIN: assert property (
        !loop |=> o_user_output_two_n == !$past(ctl_q[`UMCL_CTL_USR2]))
        else $error("user output two pin wrong");

    AST_LOOP_PINS_IDLE: assert property (
        loop ##1 loop |-> o_request_send_out_n &&
            o_terminal_ready_out_n && o_user_output_two_n)
        else $error("modem outputs active in loopback");

    AST_CD_FROM_OP2: assert property (
        loop |=> mst_q.cd == $past(ctl_q[`UMCL_CTL_USR2]))
        else $error("carrier detect not from bit 3");

    AST_RI_FROM_OP1: assert property (
        loop |=> mst_q.ri == $past(ctl_q[`UMCL_CTL_RING]))
        else $error("ring not from bit 2");

    AST_CTS_DSR_LOOP: assert property (
        loop |=> mst_q.cts == $past(ctl_q[`UMCL_CTL_RTS]) &&
            mst_q.dsr == $past(ctl_q[`UMCL_CTL_DTR]))
        else $error("cts or dsr not from control bits");

    AST_CTS_EVENT: assert property (
        $changed(mst_q.cts) |-> ist_q[`UMCL_EV_CTS])
        else $error("cts change did not set status");

    AST_RX_EVENT: assert property (
        i_rx_event |=> ist_q[`UMCL_EV_RX])
        else $error("rx event lost");

    AST_IRQ_GATE: assert property (
        (ist_q & mask_q) == `UMCL_IRQ_RST |=> !o_irq)
        else $error("interrupt not gated by enables");

    AST_RSV_ZERO: assert property (
        rd_pend_q && req_q.addr == `UMCL_ADDR_CTL |=>
            o_hrdata[`UMCL_RSV_HI:`UMCL_RSV_LO] == 3'h0)
        else $error("reserved bits read non-zero");

    COV_LOOP_ENTER: cover property (!loop ##1 loop);
    COV_IRQ: cover property (!o_irq ##1 o_irq);
    COV_LOOP_CTS: cover property (loop && $rose(mst_q.cts));
    COV_READ: cover property (rd_pend_q ##1 o_hreadyout);
endmodule // umcl_top

// ==== umcl_modem_model.sv ====
`timescale 1ns/1ps
module umcl_modem_model (
    input wire logic i_serial_out,
    input wire logic i_request_send_out_n,
    input wire logic i_terminal_ready_out_n,
    input wire logic i_carrier_n,
    input wire logic i_ring_n,
    output logic o_serial_in,
    output logic o_clear_to_send_n,
    output logic o_data_set_ready_n,
    output logic o_carrier_detect_n,
    output logic o_call_alert_n
);
    // far end wired back on itself: rts answered by cts, dtr by dsr
    assign o_serial_in = i_serial_out;
    assign o_clear_to_send_n = i_request_send_out_n;
    assign o_data_set_ready_n = i_terminal_ready_out_n;
    // carrier and ring stay under bench control
    assign o_carrier_detect_n = i_carrier_n;
    assign o_call_alert_n = i_ring_n;
endmodule // umcl_modem_model

// ==== test_uart_modem_control_loopback.sv ====
`timescale 1ns/1ps
module test_uart_modem_control_loopback;
    import umcl_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic tx_bit = 1'b1;
    logic rx_ev = 1'b0;
    logic tx_ev = 1'b0;
    logic carrier_n = 1'b1;
    logic ring_n = 1'b1;
    logic [31:0] hrdata, rd;
    logic hready, hresp, irq;
    logic ser_in, cts_n, dsr_n, cd_n, ri_n;
    logic ser_out, rx_bit, rts_n, dtr_n, op2_n;
    umcl_modem_type mstat;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;

    umcl_top i_umcl_top (.i_clk(clk), .i_reset_n(rst_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_serial_in(ser_in), .i_clear_to_send_in_n(cts_n),
        .i_data_set_ready_in_n(dsr_n), .i_carrier_detect_in_n(cd_n),
        .i_call_alert_in_n(ri_n), .i_tx_bit(tx_bit), .i_rx_event(rx_ev),
        .i_tx_event(tx_ev), .o_serial_out(ser_out), .o_rx_bit(rx_bit),
        .o_request_send_out_n(rts_n), .o_terminal_ready_out_n(dtr_n),
        .o_user_output_two_n(op2_n), .o_modem_status(mstat), .o_irq(irq));

    umcl_modem_model i_umcl_modem_model (.i_serial_out(ser_out),
        .i_request_send_out_n(rts_n), .i_terminal_ready_out_n(dtr_n),
        .i_carrier_n(carrier_n), .i_ring_n(ring_n), .o_serial_in(ser_in),
        .o_clear_to_send_n(cts_n), .o_data_set_ready_n(dsr_n),
        .o_carrier_detect_n(cd_n), .o_call_alert_n(ri_n));

    initial forever #5 clk = ~clk;

    task automatic wrap_up;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ceiling well above the hundred-odd cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask

    // no fixed wait assumed: both phases wait on hready
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task automatic rchk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, exp, rd);
        chk("hresp", 32'h0, hresp);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic t_reset;
        rchk("ctrl", 8'h00, 32'h0);
        chk("rts_n", 1, rts_n);
        chk("dtr_n", 1, dtr_n);
        chk("op2_n", 1, op2_n);
        chk("irq", 0, irq);
    endtask

    task automatic t_normal;
        bus(1'b1, 8'h08, 32'h01);
        @(posedge clk);
        tx_bit <= 1'b0;
        bus(1'b1, 8'h00, 32'h0b);
        wt(6);
        chk("op2_n", 0, op2_n);
        chk("rts_n", 0, rts_n);
        chk("dtr_n", 0, dtr_n);
        chk("serial_out", 0, ser_out);
        chk("rx_bit", 0, rx_bit);
        chk("irq", 1, irq);
        rchk("status", 8'h04, 32'h33);
        bus(1'b1, 8'h0c, 32'h03);
        wt(3);
        chk("irq clr", 0, irq);
    endtask

    task automatic t_mask;
        bus(1'b1, 8'h08, 32'h00);
        @(posedge clk);
        carrier_n <= 1'b0;
        wt(6);
        chk("irq masked", 0, irq);
        rchk("events", 8'h0c, 32'h08);
        bus(1'b1, 8'h0c, 32'h08);
    endtask

    task automatic t_loop;
        bus(1'b1, 8'h00, 32'h16);
        wt(6);
        chk("rts_n", 1, rts_n);
        chk("dtr_n", 1, dtr_n);
        chk("op2_n", 1, op2_n);
        chk("serial_out", 1, ser_out);
        bus(1'b1, 8'h0c, 32'h3f);
        bus(1'b1, 8'h00, 32'h1a);
        @(posedge clk);
        ring_n <= 1'b0;
        wt(6);
        chk("mstat", 4'h9, mstat);
        rchk("status", 8'h04, 32'h9c);
        @(posedge clk);
        tx_bit <= 1'b1;
        wt(3);
        chk("rx_bit hi", 1, rx_bit);
        @(posedge clk);
        tx_bit <= 1'b0;
        wt(3);
        chk("rx_bit lo", 0, rx_bit);
        chk("serial_out", 1, ser_out);
        rchk("ctrl", 8'h00, 32'h1a);
    endtask

    task automatic t_events;
        bus(1'b1, 8'h08, 32'h30);
        bus(1'b1, 8'h0c, 32'h3f);
        @(posedge clk);
        rx_ev <= 1'b1;
        @(posedge clk);
        rx_ev <= 1'b0;
        wt(3);
        chk("irq rx", 1, irq);
        rchk("events rx", 8'h0c, 32'h10);
        bus(1'b1, 8'h0c, 32'h10);
        wt(3);
        chk("irq clr", 0, irq);
        @(posedge clk);
        tx_ev <= 1'b1;
        @(posedge clk);
        tx_ev <= 1'b0;
        wt(3);
        chk("irq tx", 1, irq);
        rchk("events tx", 8'h0c, 32'h20);
        rchk("unmapped", 8'h10, 32'h0);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_normal();
        t_mask();
        t_loop();
        t_events();
        wrap_up();
    end
endmodule // test_uart_modem_control_loopback
